//--- ldm_consts.svh
// constants for the line driver fault monitor: offsets, fields, resets, times
`ifndef LDM_CONSTS_SVH
`define LDM_CONSTS_SVH

// system clock rate
`define LDM_CLK_HZ 10000000

// register offsets
`define LDM_ADDR_STATUS 2'h0
`define LDM_ADDR_LINE_CFG 2'h1
`define LDM_ADDR_AUX_CFG 2'h2
`define LDM_ADDR_MODE 2'h3

// status register fields
`define LDM_ST_AUX_IRQ 6
`define LDM_ST_AUX_LVL 5
`define LDM_ST_LINE_LVL 4
`define LDM_ST_LINE_IRQ 3
`define LDM_ST_R33_IRQ 2
`define LDM_ST_FLD_IRQ 1

// line configuration fields
`define LDM_LC_RX_FILTER 7
`define LDM_LC_FAST_SLEW 6
`define LDM_LC_NPN_PNP 5
`define LDM_LC_PUSH_PULL 4
`define LDM_LC_RX_DIS 1

// aux configuration fields
`define LDM_AC_NPN_PNP 5
`define LDM_AC_PUSH_PULL 4

// mode register fields
`define LDM_MD_AUX_FAULT 5
`define LDM_MD_LINE_FAULT 4
`define LDM_MD_FLD_UV 3
`define LDM_MD_R33_UV_EN 1
`define LDM_MD_R33_DIS 0

// reset values
`define LDM_CFG_RST 8'h00
`define LDM_RDATA_RST 8'h00

// fault times in ns
`define LDM_LINE_QUAL_NS 140000
`define LDM_LINE_OFF_NS 240000
`define LDM_AUX_QUAL_NS 440000
`define LDM_RETRY_PERIOD_NS 26000000

`endif

//--- ldm_line_driver_fault_monitor.sv
// line transceiver control, fault timing with auto-retry and supply supervision
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "ldm_consts.svh"

module ldm_line_driver_fault_monitor import ldm_pkg::*; #(
	parameter int AUX_QUAL_CYC = (`LDM_AUX_QUAL_NS * (`LDM_CLK_HZ / 1000000) + 999) / 1000,
	parameter int RETRY_PERIOD_CYC = (`LDM_RETRY_PERIOD_NS * (`LDM_CLK_HZ / 1000000)) / 1000
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// transmit side from the microcontroller
	input wire logic line_tx_enable,
	input wire logic tx_comm_in,
	input wire logic tx_level_in,
	input wire logic aux_out_in,
	// line and aux analog sense
	input wire logic line_level_in,
	input wire logic line_in_window,
	input wire logic line_overcurrent,
	input wire logic aux_overcurrent,
	input wire logic aux_digital_in,
	// supply monitors, high while above threshold
	input wire logic field_supply_ok,
	input wire logic core_5v_supply_ok,
	input wire logic logic_level_supply_ok,
	input wire logic regulator_3v3_ok,
	// driver switches and analog settings
	output logic line_hs_on,
	output logic line_ls_on,
	output logic aux_hs_on,
	output logic aux_ls_on,
	output logic fast_slew_sel,
	output logic rx_filter_sel,
	output logic regulator_3v3_en,
	// receive outputs
	output logic line_receive_out,
	output logic aux_logic_out,
	// open-drain indicators, enable low while pulling low
	output logic undervoltage_out,
	output logic undervoltage_out_oe_n,
	output logic interrupt_out_n,
	output logic interrupt_out_oe_n
);

	// interval counts in system clock cycles
	localparam int LINE_QUAL_CYC = (`LDM_LINE_QUAL_NS * (`LDM_CLK_HZ / 1000000) + 999) / 1000;
	localparam int LINE_OFF_CYC = (`LDM_LINE_OFF_NS * (`LDM_CLK_HZ / 1000000)) / 1000;

	// decode of a strobed access to one register
	function automatic logic reg_hit(input logic [1:0] addr, input logic [1:0] target, input logic strobe);
		reg_hit = strobe && (addr == target);
	endfunction

	logic [7:0] line_cfg, next_line_cfg;
	logic [7:0] aux_cfg, next_aux_cfg;
	logic [1:0] mode_cfg, next_mode_cfg;
	logic line_irq, next_line_irq;
	logic aux_irq, next_aux_irq;
	logic fld_irq, next_fld_irq;
	logic r33_irq, next_r33_irq;
	logic fld_uv_q, next_fld_uv_q;
	logic r33_uv_q, next_r33_uv_q;
	logic powered_up, next_powered_up;
	logic [7:0] next_reg_rdata;
	logic bus_ok;
	logic wr_ok;
	logic rd_ok;
	logic status_rd;
	logic drv_ok;
	logic uv_assert;
	logic [1:0] fcond;
	logic [1:0] fault_act;
	logic [1:0] drv_block;
	logic line_level_cmd;
	logic line_en;
	logic aux_level_cmd;
	logic next_line_hs_on;
	logic next_line_ls_on;
	logic next_aux_hs_on;
	logic next_aux_ls_on;
	logic next_line_receive_out;
	logic next_aux_logic_out;
	logic next_uv_oe_n;
	logic next_irq_oe_n;

	// bus is dead while core or logic supply is low
	assign bus_ok = core_5v_supply_ok && logic_level_supply_ok;
	assign wr_ok = reg_wr && bus_ok;
	assign rd_ok = reg_rd && bus_ok;
	assign status_rd = reg_hit(reg_addr, `LDM_ADDR_STATUS, rd_ok);

	// drivers only run once powered up and all hard supplies are good
	assign drv_ok = powered_up && field_supply_ok && core_5v_supply_ok && logic_level_supply_ok;

	// indicator asserts on any hard supply, and on 3.3V only when enabled
	assign uv_assert = !field_supply_ok || !core_5v_supply_ok || !logic_level_supply_ok ||
		(!regulator_3v3_ok && mode_cfg[`LDM_MD_R33_UV_EN]);

	// line level is the inverse of the two transmit inputs ANDed
	assign line_level_cmd = !(tx_comm_in && tx_level_in);
	// aux output drives the inverse of its logic input
	assign aux_level_cmd = !aux_out_in;
	// line enable follows the transmit enable input, gated by power and the fault timer
	assign line_en = line_tx_enable && drv_ok && !drv_block[0];

	// overcurrent, or open-drain line switched off yet stuck between thresholds
	assign fcond[0] = line_overcurrent ||
		(!line_cfg[`LDM_LC_PUSH_PULL] && !line_hs_on && !line_ls_on && line_in_window);
	assign fcond[1] = aux_overcurrent;

	// one fault timer per output; index 0 is the line, 1 is aux
	for (genvar g = 0; g < 2; g++) begin : g_fault
		localparam ldm_cnt_t QUAL = ldm_cnt_t'(g == 0 ? LINE_QUAL_CYC : AUX_QUAL_CYC);
		localparam ldm_cnt_t OFFC = ldm_cnt_t'(g == 0 ? LINE_OFF_CYC : AUX_QUAL_CYC);
		localparam ldm_cnt_t PERIOD = ldm_cnt_t'(RETRY_PERIOD_CYC - 1);
		localparam ldm_cnt_t WINDOW = ldm_cnt_t'((g == 0 ? LINE_OFF_CYC : AUX_QUAL_CYC) - 1);
		ldm_fault_e st, next_st;
		ldm_cnt_t cnt, next_cnt;
		logic act, next_act;

		// qualify, cut off, then probe periodically until the fault is gone
		always_comb begin
			next_st = st;
			next_cnt = cnt;
			next_act = act;
			unique case (st)
				FLT_IDLE: begin
					next_cnt = '0;
					next_act = 1'b0;
					if (fcond[g]) begin
						next_st = FLT_QUAL;
						next_cnt = ldm_cnt_t'(1);
					end
				end
				FLT_QUAL: begin
					if (!fcond[g]) begin
						next_st = FLT_IDLE;
						next_act = 1'b0;
					end else begin
						next_cnt = cnt + ldm_cnt_t'(1);
						if (cnt == QUAL) begin
							next_act = 1'b1;
						end
						if (cnt == OFFC) begin
							next_st = FLT_OFF;
							next_cnt = '0;
						end
					end
				end
				FLT_OFF: begin
					next_cnt = cnt + ldm_cnt_t'(1);
					if (cnt == PERIOD) begin
						next_st = FLT_RETRY;
						next_cnt = '0;
					end
				end
				FLT_RETRY: begin
					next_cnt = cnt + ldm_cnt_t'(1);
					// judged at the end of the window so inrush at turn-on is not mistaken for a short
					if (cnt == WINDOW) begin
						next_cnt = '0;
						if (fcond[g]) begin
							next_st = FLT_OFF;
						end else begin
							next_st = FLT_IDLE;
							next_act = 1'b0;
						end
					end
				end
			endcase
		end

		// fault timer registers
		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				st <= FLT_IDLE;
				cnt <= '0;
				act <= 1'b0;
			end else begin
				st <= next_st;
				cnt <= next_cnt;
				act <= next_act;
			end
		end

		assign fault_act[g] = act;
		assign drv_block[g] = (st == FLT_OFF);
	end

	// configuration writes and sticky interrupt flags
	always_comb begin
		next_line_cfg = line_cfg;
		next_aux_cfg = aux_cfg;
		next_mode_cfg = mode_cfg;
		// only a reset clears configuration, never a field or 3.3V dip
		if (reg_hit(reg_addr, `LDM_ADDR_LINE_CFG, wr_ok)) begin
			next_line_cfg = reg_wdata;
		end
		if (reg_hit(reg_addr, `LDM_ADDR_AUX_CFG, wr_ok)) begin
			next_aux_cfg = reg_wdata;
		end
		if (reg_hit(reg_addr, `LDM_ADDR_MODE, wr_ok)) begin
			next_mode_cfg = reg_wdata[1:0];
		end
		next_fld_uv_q = !field_supply_ok;
		next_r33_uv_q = !regulator_3v3_ok;
		// read clears, but a set in the same cycle wins
		next_line_irq = (line_irq && !status_rd) || fault_act[0];
		next_aux_irq = (aux_irq && !status_rd) || fault_act[1];
		next_fld_irq = (fld_irq && !status_rd) || (!field_supply_ok && !fld_uv_q);
		next_r33_irq = (r33_irq && !status_rd) || (!regulator_3v3_ok && !r33_uv_q);
		// power-up completes once every monitored supply clears lockout
		next_powered_up = powered_up || (field_supply_ok && core_5v_supply_ok &&
			logic_level_supply_ok && regulator_3v3_ok);
	end

	// configuration and flag registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			line_cfg <= `LDM_CFG_RST;
			aux_cfg <= `LDM_CFG_RST;
			mode_cfg <= 2'h0;
			line_irq <= 1'b0;
			aux_irq <= 1'b0;
			fld_irq <= 1'b0;
			r33_irq <= 1'b0;
			fld_uv_q <= 1'b0;
			r33_uv_q <= 1'b0;
			powered_up <= 1'b0;
		end else begin
			line_cfg <= next_line_cfg;
			aux_cfg <= next_aux_cfg;
			mode_cfg <= next_mode_cfg;
			line_irq <= next_line_irq;
			aux_irq <= next_aux_irq;
			fld_irq <= next_fld_irq;
			r33_irq <= next_r33_irq;
			fld_uv_q <= next_fld_uv_q;
			r33_uv_q <= next_r33_uv_q;
			powered_up <= next_powered_up;
		end
	end

	// read data, valid only in the cycle after the strobe; silent when the bus is dead
	always_comb begin
		next_reg_rdata = `LDM_RDATA_RST;
		if (rd_ok) begin
			unique case (reg_addr)
				`LDM_ADDR_STATUS: begin
					next_reg_rdata[`LDM_ST_AUX_IRQ] = aux_irq;
					next_reg_rdata[`LDM_ST_AUX_LVL] = aux_digital_in;
					next_reg_rdata[`LDM_ST_LINE_LVL] = line_level_in;
					next_reg_rdata[`LDM_ST_LINE_IRQ] = line_irq;
					next_reg_rdata[`LDM_ST_R33_IRQ] = r33_irq;
					next_reg_rdata[`LDM_ST_FLD_IRQ] = fld_irq;
				end
				`LDM_ADDR_LINE_CFG: begin
					next_reg_rdata = line_cfg;
				end
				`LDM_ADDR_AUX_CFG: begin
					next_reg_rdata = aux_cfg;
				end
				`LDM_ADDR_MODE: begin
					next_reg_rdata[`LDM_MD_AUX_FAULT] = fault_act[1];
					next_reg_rdata[`LDM_MD_LINE_FAULT] = fault_act[0];
					next_reg_rdata[`LDM_MD_FLD_UV] = !field_supply_ok;
					next_reg_rdata[1:0] = mode_cfg;
				end
			endcase
		end
	end

	// driver switch selection and pin outputs
	always_comb begin
		// push-pull uses both switches, open-drain only the chosen side
		if (line_cfg[`LDM_LC_PUSH_PULL]) begin
			next_line_hs_on = line_en && line_level_cmd;
			next_line_ls_on = line_en && !line_level_cmd;
		end else begin
			next_line_hs_on = line_en && line_cfg[`LDM_LC_NPN_PNP] && line_level_cmd;
			next_line_ls_on = line_en && !line_cfg[`LDM_LC_NPN_PNP] && !line_level_cmd;
		end
		// aux output has no enable pin: power and fault timer gate it
		if (aux_cfg[`LDM_AC_PUSH_PULL]) begin
			next_aux_hs_on = drv_ok && !drv_block[1] && aux_level_cmd;
			next_aux_ls_on = drv_ok && !drv_block[1] && !aux_level_cmd;
		end else begin
			next_aux_hs_on = drv_ok && !drv_block[1] && aux_cfg[`LDM_AC_NPN_PNP] && aux_level_cmd;
			next_aux_ls_on = drv_ok && !drv_block[1] && !aux_cfg[`LDM_AC_NPN_PNP] && !aux_level_cmd;
		end
		// receiver keeps running; the disable bit only pins the output high
		next_line_receive_out = line_cfg[`LDM_LC_RX_DIS] || !line_level_in;
		next_aux_logic_out = !aux_digital_in;
		// indicator released until powered up and again during undervoltage
		next_uv_oe_n = !(powered_up && !uv_assert);
		// interrupt pulls low while any flag stands, unless the logic is unpowered
		next_irq_oe_n = !((line_irq || aux_irq || fld_irq || r33_irq) && bus_ok);
	end

	// pin registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata <= `LDM_RDATA_RST;
			line_hs_on <= 1'b0;
			line_ls_on <= 1'b0;
			aux_hs_on <= 1'b0;
			aux_ls_on <= 1'b0;
			line_receive_out <= 1'b1;
			aux_logic_out <= 1'b1;
			undervoltage_out_oe_n <= 1'b1;
			interrupt_out_oe_n <= 1'b1;
		end else begin
			reg_rdata <= next_reg_rdata;
			line_hs_on <= next_line_hs_on;
			line_ls_on <= next_line_ls_on;
			aux_hs_on <= next_aux_hs_on;
			aux_ls_on <= next_aux_ls_on;
			line_receive_out <= next_line_receive_out;
			aux_logic_out <= next_aux_logic_out;
			undervoltage_out_oe_n <= next_uv_oe_n;
			interrupt_out_oe_n <= next_irq_oe_n;
		end
	end

	// analog settings straight from configuration
	assign fast_slew_sel = line_cfg[`LDM_LC_FAST_SLEW];
	assign rx_filter_sel = line_cfg[`LDM_LC_RX_FILTER];
	assign regulator_3v3_en = !mode_cfg[`LDM_MD_R33_DIS];
	// open-drain pins only ever pull low
	assign undervoltage_out = 1'b0;
	assign interrupt_out_n = 1'b0;

endmodule

//--- ldm_line_driver_fault_monitor_assertions.sv
// port checker for the line driver fault monitor
`timescale 1ns/10ps
`include "ldm_consts.svh"
module ldm_line_driver_fault_monitor_assertions #(
	parameter int AUX_QUAL_CYC = 4400,
	parameter int RETRY_PERIOD_CYC = 260000
) (
	// clock and register port
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [7:0] reg_rdata,
	// sense and supplies
	input wire logic line_overcurrent,
	input wire logic aux_overcurrent,
	input wire logic field_supply_ok,
	input wire logic core_5v_supply_ok,
	input wire logic logic_level_supply_ok,
	// outputs
	input wire logic line_hs_on,
	input wire logic line_ls_on,
	input wire logic aux_hs_on,
	input wire logic aux_ls_on,
	input wire logic fast_slew_sel,
	input wire logic rx_filter_sel,
	input wire logic regulator_3v3_en,
	input wire logic line_receive_out,
	input wire logic interrupt_out_oe_n
);
	localparam int LQ = `LDM_LINE_QUAL_NS * (`LDM_CLK_HZ / 1000000) / 1000;
	localparam int LO = `LDM_LINE_OFF_NS * (`LDM_CLK_HZ / 1000000) / 1000;
	logic ok;
	logic [7:0] lc, next_lc;
	logic [1:0] md, next_md;
	int ol, oa, next_ol, next_oa;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	assign ok = core_5v_supply_ok & logic_level_supply_ok;
	// shadow config and overcurrent run lengths; refused writes must not touch the shadow
	always_comb begin
		next_lc = lc;
		next_md = md;
		if (reg_wr && ok && reg_addr == `LDM_ADDR_LINE_CFG)
			next_lc = reg_wdata;
		if (reg_wr && ok && reg_addr == `LDM_ADDR_MODE)
			next_md = reg_wdata[1:0];
		next_ol = line_overcurrent ? ol + 1 : 0;
		next_oa = aux_overcurrent ? oa + 1 : 0;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lc <= 8'h00;
			md <= 2'h0;
			ol <= 0;
			oa <= 0;
		end else begin
			lc <= next_lc;
			md <= next_md;
			ol <= next_ol;
			oa <= next_oa;
		end
	end
	property p_rx_dis;
		lc[`LDM_LC_RX_DIS] |=> line_receive_out;
	endproperty
	a_rx_dis: assert property (p_rx_dis) else $error("receive out not forced high");
	property p_sel;
		rx_filter_sel == lc[`LDM_LC_RX_FILTER] && fast_slew_sel == lc[`LDM_LC_FAST_SLEW];
	endproperty
	a_sel: assert property (p_sel) else $error("filter or slew select wrong");
	property p_reg33;
		regulator_3v3_en == !md[`LDM_MD_R33_DIS];
	endproperty
	a_reg33: assert property (p_reg33) else $error("regulator enable wrong");
	property p_supply_off;
		!field_supply_ok [*3] |-> !(line_hs_on || line_ls_on || aux_hs_on || aux_ls_on);
	endproperty
	a_supply_off: assert property (p_supply_off) else $error("driver on in undervoltage");
	property p_core;
		!core_5v_supply_ok [*2] |-> interrupt_out_oe_n && reg_rdata == 8'h00;
	endproperty
	a_core: assert property (p_core) else $error("active while core supply low");
	property p_aux;
		oa == AUX_QUAL_CYC + 5 && ok |-> !interrupt_out_oe_n && !aux_hs_on && !aux_ls_on;
	endproperty
	a_aux: assert property (p_aux) else $error("aux short not handled");
	property p_line_irq;
		ol == LQ + 4 && ok |-> !interrupt_out_oe_n;
	endproperty
	a_line_irq: assert property (p_line_irq) else $error("line short not flagged");
	property p_line_off;
		ol == LO + 5 |-> !line_hs_on && !line_ls_on;
	endproperty
	a_line_off: assert property (p_line_off) else $error("line driver not off");
endmodule
bind ldm_line_driver_fault_monitor ldm_line_driver_fault_monitor_assertions #(.AUX_QUAL_CYC(AUX_QUAL_CYC),
	.RETRY_PERIOD_CYC(RETRY_PERIOD_CYC)) i_chk (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
	.line_overcurrent, .aux_overcurrent, .field_supply_ok, .core_5v_supply_ok, .logic_level_supply_ok,
	.line_hs_on, .line_ls_on, .aux_hs_on, .aux_ls_on, .fast_slew_sel, .rx_filter_sel, .regulator_3v3_en,
	.line_receive_out, .interrupt_out_oe_n);

//--- ldm_line_driver_fault_monitor_tb.sv
// self-checking bench for the line driver fault monitor
`timescale 1ns/10ps
`include "ldm_consts.svh"
module ldm_line_driver_fault_monitor_tb;
	logic clk_sys = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
	logic [3:0] tx_cmd = 4'h7;
	logic line_level_in = 1'h0, line_in_window = 1'h0, line_overcurrent = 1'h0, aux_overcurrent = 1'h0;
	logic aux_digital_in = 1'h0, field_supply_ok = 1'h0, core_5v_supply_ok = 1'h1;
	logic logic_level_supply_ok = 1'h1, regulator_3v3_ok = 1'h1;
	logic line_tx_enable, tx_comm_in, tx_level_in, aux_out_in, line_hs_on, line_ls_on, aux_hs_on, aux_ls_on;
	logic fast_slew_sel, rx_filter_sel, regulator_3v3_en, line_receive_out, aux_logic_out;
	logic undervoltage_out, undervoltage_out_oe_n, interrupt_out_n, interrupt_out_oe_n;
	int n_fail = 0, tests_run = 0;
	always #50 clk_sys = ~clk_sys;
	ldm_mcu_model i_mcu (.clk_sys, .tx_cmd, .line_tx_enable, .tx_comm_in, .tx_level_in, .aux_out_in);
	// short counts keep the aux and retry timing quick
	ldm_line_driver_fault_monitor #(.AUX_QUAL_CYC(20), .RETRY_PERIOD_CYC(50)) i_dut (.clk_sys, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .line_tx_enable, .tx_comm_in, .tx_level_in, .aux_out_in,
		.line_level_in, .line_in_window, .line_overcurrent, .aux_overcurrent, .aux_digital_in, .field_supply_ok,
		.core_5v_supply_ok, .logic_level_supply_ok, .regulator_3v3_ok, .line_hs_on, .line_ls_on, .aux_hs_on,
		.aux_ls_on, .fast_slew_sel, .rx_filter_sel, .regulator_3v3_en, .line_receive_out, .aux_logic_out,
		.undervoltage_out, .undervoltage_out_oe_n, .interrupt_out_n, .interrupt_out_oe_n);
	// compare what stood during the cycle that ends at this edge; design flops update after it
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle register write and read
	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [1:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		// read data stand only in the cycle after the strobe, so take them at its closing edge
		@(posedge clk_sys);
		d = reg_rdata;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task results;
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// expected switches: m 0 push-pull, 1 low side, 2 high side; c is {enable, comm, level, aux}
	function automatic logic [3:0] sw(input int m, input logic [3:0] c);
		logic l, a, hs, ls;
		l = ~(c[2] & c[1]);
		a = ~c[0];
		hs = m != 1;
		ls = m != 2;
		return {c[3] & l & hs, c[3] & ~l & ls, a & hs, ~a & ls};
	endfunction
	task t_cfg;
		line_level_in <= 1'h1;
		aux_digital_in <= 1'h1;
		wr(`LDM_ADDR_LINE_CFG, 8'hC2);
		cyc(2);
		chk({fast_slew_sel, rx_filter_sel, line_receive_out, aux_logic_out}, 8'h0E);
		// receiver keeps sensing while its output is forced high
		rd(`LDM_ADDR_STATUS);
		chk(d[`LDM_ST_AUX_LVL:`LDM_ST_LINE_LVL], 8'h03);
		aux_digital_in <= 1'h0;
		wr(`LDM_ADDR_LINE_CFG, 8'h00);
		cyc(2);
		chk({fast_slew_sel, rx_filter_sel, line_receive_out, aux_logic_out}, 8'h01);
		wr(`LDM_ADDR_MODE, 8'hFF);
		rd(`LDM_ADDR_MODE);
		chk({d[6:0], regulator_3v3_en}, 8'h06);
		wr(`LDM_ADDR_MODE, 8'h00);
	endtask
	task t_modes;
		for (int m = 0; m < 3; m++) begin
			wr(`LDM_ADDR_LINE_CFG, {2'h0, m == 2, m == 0, 4'h0});
			wr(`LDM_ADDR_AUX_CFG, {2'h0, m == 2, m == 0, 4'h0});
			for (int v = 0; v < 16; v++) begin
				tx_cmd <= v[3:0];
				cyc(3);
				chk({line_hs_on, line_ls_on, aux_hs_on, aux_ls_on}, sw(m, v[3:0]));
			end
		end
	endtask
	task t_uv;
		tx_cmd <= 4'hC;
		field_supply_ok <= 1'h0;
		cyc(4);
		chk({undervoltage_out_oe_n, interrupt_out_oe_n, line_hs_on, aux_hs_on}, 8'h08);
		rd(`LDM_ADDR_MODE);
		chk(d[`LDM_MD_FLD_UV], 1'h1);
		field_supply_ok <= 1'h1;
		cyc(3);
		chk({undervoltage_out_oe_n, interrupt_out_oe_n}, 8'h00);
		rd(`LDM_ADDR_STATUS);
		chk(d[`LDM_ST_FLD_IRQ], 1'h1);
		cyc(3);
		chk(interrupt_out_oe_n, 1'h1);
		regulator_3v3_ok <= 1'h0;
		cyc(3);
		chk({undervoltage_out_oe_n, interrupt_out_oe_n}, 8'h00);
		wr(`LDM_ADDR_MODE, 8'h02);
		cyc(3);
		chk(undervoltage_out_oe_n, 1'h1);
		regulator_3v3_ok <= 1'h1;
		rd(`LDM_ADDR_STATUS);
		chk({d[`LDM_ST_R33_IRQ], undervoltage_out_oe_n}, 8'h02);
		core_5v_supply_ok <= 1'h0;
		wr(`LDM_ADDR_LINE_CFG, 8'hAA);
		rd(`LDM_ADDR_LINE_CFG);
		chk(d, 8'h00);
		core_5v_supply_ok <= 1'h1;
		rd(`LDM_ADDR_LINE_CFG);
		chk(d, 8'h20);
	endtask
	task t_aux;
		wr(`LDM_ADDR_AUX_CFG, 8'h10);
		tx_cmd <= 4'h0;
		aux_overcurrent <= 1'h1;
		cyc(18);
		chk({interrupt_out_oe_n, aux_hs_on}, 8'h03);
		cyc(8);
		chk({interrupt_out_oe_n, aux_hs_on}, 8'h00);
		rd(`LDM_ADDR_STATUS);
		chk(d[`LDM_ST_AUX_IRQ], 1'h1);
		rd(`LDM_ADDR_STATUS);
		chk(d[`LDM_ST_AUX_IRQ], 1'h1);
		aux_overcurrent <= 1'h0;
		cyc(30);
		chk(aux_hs_on, 1'h0);
		cyc(30);
		chk(aux_hs_on, 1'h1);
		cyc(30);
		rd(`LDM_ADDR_MODE);
		chk(d[`LDM_MD_AUX_FAULT], 1'h0);
		rd(`LDM_ADDR_STATUS);
		cyc(3);
		chk(interrupt_out_oe_n, 1'h1);
	endtask
	task t_line;
		wr(`LDM_ADDR_LINE_CFG, 8'h10);
		tx_cmd <= 4'hC;
		line_overcurrent <= 1'h1;
		cyc(1396);
		chk({interrupt_out_oe_n, line_hs_on}, 8'h03);
		cyc(10);
		chk({interrupt_out_oe_n, line_hs_on}, 8'h01);
		cyc(1002);
		chk(line_hs_on, 1'h0);
		line_overcurrent <= 1'h0;
		cyc(36);
		chk(line_hs_on, 1'h0);
		cyc(20);
		chk(line_hs_on, 1'h1);
		cyc(2450);
		rd(`LDM_ADDR_STATUS);
		chk(d[`LDM_ST_LINE_IRQ], 1'h1);
		wr(`LDM_ADDR_LINE_CFG, 8'h00);
		tx_cmd <= 4'h0;
		line_in_window <= 1'h1;
		cyc(1410);
		rd(`LDM_ADDR_MODE);
		chk(d[`LDM_MD_LINE_FAULT], 1'h1);
		line_in_window <= 1'h0;
	endtask
	// power-up with the field supply still low: nothing drives until every supply is good
	task t_power;
		cyc(4);
		chk({undervoltage_out_oe_n, aux_ls_on, regulator_3v3_en, fast_slew_sel}, 8'h0A);
		field_supply_ok <= 1'h1;
		cyc(3);
		chk({undervoltage_out, interrupt_out_n, undervoltage_out_oe_n, aux_ls_on}, 8'h01);
		rd(`LDM_ADDR_STATUS);
		chk(d[`LDM_ST_FLD_IRQ], 1'h1);
	endtask
	// main sequence: reset for six cycles, then each scenario in turn
	initial begin
		cyc(6);
		rst_n <= 1'h1;
		t_power();
		t_cfg();
		t_modes();
		t_uv();
		t_aux();
		t_line();
		results();
	end
	// watchdog well beyond the expected run
	initial begin
		#3000000;
		n_fail++;
		results();
	end
endmodule

//--- ldm_mcu_model.sv
// microcontroller model driving the transmit pins
`timescale 1ns/10ps
module ldm_mcu_model (
	// clock and command
	input wire logic clk_sys,
	input wire logic [3:0] tx_cmd,
	// transmit pins
	output logic line_tx_enable,
	output logic tx_comm_in,
	output logic tx_level_in,
	output logic aux_out_in
);
	// idle with the driver off and both data pins high
	logic [3:0] pins = 4'h7;
	// pins move just after an edge and hold until the next command
	always @(posedge clk_sys) pins <= tx_cmd;
	assign {line_tx_enable, tx_comm_in, tx_level_in, aux_out_in} = pins;
endmodule

//--- ldm_pkg.sv
// types for the line driver fault monitor
package ldm_pkg;
	typedef enum logic [1:0] {
		FLT_IDLE = 2'b00,
		FLT_QUAL = 2'b01,
		FLT_OFF = 2'b10,
		FLT_RETRY = 2'b11
	} ldm_fault_e;
	typedef logic [17:0] ldm_cnt_t;
endpackage
